// *** design/fsc_fetch_ctrl.sv ***
// fetch major-state control with axi4-lite register access
// Functional notes
// - skip flag cleared in time state one of every fetch.
// - fetch loads program counter with address register plus injected carry.
// - accumulator driven on the shared data bus during fetch.
// - memory word drives the memory data bus only while direction high.
// - top three memory data bits decoded into instruction type.
// - opcode 7 is an operate instruction.
// - operate group chosen from memory data bits 3 and 11.
// - opcode 6 is an i/o transfer instruction.
// - time state three runs augmented ops, starts write-back, loads ac.
// - time state four updates address, ends write-back, sets next state.
// - interrupt forces jump-subroutine, execute state, zero address.
// - skip set by operate or i/o in ts3, tested without interrupt.
// - skip injects carry, address gets program counter plus one.
// - without skip, address gets program counter unchanged.
// - i/o, operate or direct jump assert fetch-set.
// - jump updates counter in ts3; indirect goes to defer.
// - memory-reference ops only form address and pick next state.
// - page bit zero forces upper five address bits to zero.
// - current page takes upper five bits from current address.
// - indirect bit one sets defer, otherwise execute.
// - operate group one when bit 3 is zero.
// - operate group two when bit 3 one and bit 11 zero.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module fsc_fetch_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [11:0]      mem_addr,
    input  wire logic [11:0] mem_rdata,
    output logic             mem_read,
    output logic             mem_write,
    output logic [11:0]      memory_data_bus,
    output logic             memory_data_direction,
    output logic [11:0]      data_bus,
    output logic             data_bus_en,
    input  wire logic [11:0] ac_result,
    input  wire logic        skip_request,
    input  wire logic        interrupt_active,
    output logic             time_state_one,
    output logic             time_state_two,
    output logic             time_state_three,
    output logic             time_state_four,
    output logic             time_pulse_four,
    output logic [1:0]       major_state,
    output logic [2:0]       instruction_register,
    output logic [1:0]       operate_group,
    output logic             page_zero,
    output logic             carry_inject_n,
    output logic             fetch_set,
    output logic             defer_set,
    output logic             execute_set
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] add12(input logic [11:0] a,
                                          input logic cin);
        add12 = a + {11'd0, cin};
    endfunction

    function automatic logic [11:0] merge12(input logic [11:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fsc_pkg::fsc_ts_e    ts_q;
    fsc_pkg::fsc_ts_e    ts_d;
    fsc_pkg::fsc_major_e major_q;
    fsc_pkg::fsc_major_e major_d;
    logic [11:0] pc_q;
    logic [11:0] pc_d;
    logic [11:0] mar_q;
    logic [11:0] mar_d;
    logic [11:0] ac_q;
    logic [11:0] ac_d;
    logic [11:0] md_q;
    logic [11:0] md_d;
    logic [2:0]  ir_q;
    logic [2:0]  ir_d;
    logic        skip_q;
    logic        skip_d;
    logic        run_q;
    logic        int_s1_q;
    logic        int_s2_q;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic        aw_held_q;
    logic [7:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire aw_fire  = s_axi_awvalid && s_axi_awready;
    wire w_fire   = s_axi_wvalid && s_axi_wready;
    wire wr_go    = aw_held_q && w_held_q && !bvalid_q;
    wire ar_fire  = s_axi_arvalid && s_axi_arready;
    wire idle     = (ts_q == fsc_pkg::TS_IDLE);
    wire wr_ctrl  = wr_go && (aw_addr_q == fsc_pkg::OFS_CTRL);
    wire wr_pc    = wr_go && idle && (aw_addr_q == fsc_pkg::OFS_PC);
    wire wr_mar   = wr_go && idle && (aw_addr_q == fsc_pkg::OFS_MAR);
    wire wr_ac    = wr_go && idle && (aw_addr_q == fsc_pkg::OFS_AC);
    wire wr_known = (aw_addr_q == fsc_pkg::OFS_CTRL)
                 || (aw_addr_q == fsc_pkg::OFS_PC)
                 || (aw_addr_q == fsc_pkg::OFS_MAR)
                 || (aw_addr_q == fsc_pkg::OFS_AC);

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            fsc_pkg::OFS_CTRL:   rd_word[fsc_pkg::CTRL_RUN_BIT] = run_q;
            fsc_pkg::OFS_STATUS: begin
                rd_word[fsc_pkg::ST_MAJOR_LSB +: 2] = major_q;
                rd_word[fsc_pkg::ST_TS_LSB +: 3]    = ts_q;
                rd_word[fsc_pkg::ST_SKIP_BIT]       = skip_q;
                rd_word[fsc_pkg::ST_INT_BIT]        = int_s2_q;
            end
            fsc_pkg::OFS_PC:     rd_word[11:0] = pc_q;
            fsc_pkg::OFS_MAR:    rd_word[11:0] = mar_q;
            fsc_pkg::OFS_AC:     rd_word[11:0] = ac_q;
            fsc_pkg::OFS_INSTR: begin
                rd_word[11:0]                     = md_q;
                rd_word[fsc_pkg::IN_OPC_LSB +: 3] = ir_q;
                rd_word[fsc_pkg::IN_GRP_LSB +: 2] = operate_group;
            end
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= fsc_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_known ? fsc_pkg::RESP_OKAY
                                      : fsc_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= fsc_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? fsc_pkg::RESP_OKAY : fsc_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire       in_fetch  = (major_q == fsc_pkg::MJ_FETCH);
    wire [2:0] opc       = md_q[fsc_pkg::MD_MSB -: 3];
    wire       is_opr    = (ir_q == fsc_pkg::OPC_OPR);
    wire       is_iot    = (ir_q == fsc_pkg::OPC_IOT);
    wire       is_jmp    = (ir_q == fsc_pkg::OPC_JMP);
    wire       augmented = is_opr || is_iot;
    wire       ind_bit   = md_q[fsc_pkg::MD_IND_BIT];
    wire       md_eleven = md_q[fsc_pkg::MD_ELEVEN_BIT];
    wire       int_now   = int_s2_q;
    fsc_pkg::fsc_ins_e ins_kind;
    assign ins_kind = fsc_pkg::fsc_ins_e'(ir_q);

    // group three when bit 3 and bit 11 are both one
    assign operate_group = !is_opr ? fsc_pkg::GRP_NONE
                         : !ind_bit ? fsc_pkg::GRP_ONE
                         : !md_eleven ? fsc_pkg::GRP_TWO
                         : fsc_pkg::GRP_THREE;

    // page-zero clears the upper five address bits
    assign page_zero = !md_q[fsc_pkg::MD_PAGE_BIT];
    wire [4:0]  page_hi   = page_zero ? 5'h00 : mar_q[11:7];
    wire [11:0] eff_addr  = {page_hi, md_q[6:0]};
    wire        skip_take = !int_now && augmented && skip_q;
    wire [11:0] seq_addr  = add12(pc_q, skip_take);

    // ------------------------------------------------------------
    // time states and major-state selection
    // ------------------------------------------------------------
    wire f_ts1 = in_fetch && (ts_q == fsc_pkg::TS_ONE);
    wire f_ts2 = in_fetch && (ts_q == fsc_pkg::TS_TWO);
    wire f_ts3 = in_fetch && (ts_q == fsc_pkg::TS_THREE);
    wire f_ts4 = in_fetch && (ts_q == fsc_pkg::TS_FOUR);

    assign fetch_set   = f_ts4 && !int_now
                      && (augmented || (is_jmp && !ind_bit));
    assign defer_set   = f_ts4 && !int_now && !augmented
                      && ind_bit;
    assign execute_set = f_ts4 && (int_now || (!augmented
                      && !is_jmp && !ind_bit));

    always_comb begin
        ts_d = ts_q;
        case (ts_q)
            fsc_pkg::TS_IDLE:  if (run_q) ts_d = fsc_pkg::TS_ONE;
            fsc_pkg::TS_ONE:   ts_d = fsc_pkg::TS_TWO;
            fsc_pkg::TS_TWO:   ts_d = fsc_pkg::TS_THREE;
            fsc_pkg::TS_THREE: ts_d = fsc_pkg::TS_FOUR;
            fsc_pkg::TS_FOUR:  ts_d = run_q ? fsc_pkg::TS_ONE
                                            : fsc_pkg::TS_IDLE;
            default:           ts_d = fsc_pkg::TS_IDLE;
        endcase
    end

    always_comb begin
        major_d = major_q;
        pc_d    = wr_pc ? merge12(pc_q, w_data_q, w_strb_q) : pc_q;
        mar_d   = wr_mar ? merge12(mar_q, w_data_q, w_strb_q) : mar_q;
        ac_d    = wr_ac ? merge12(ac_q, w_data_q, w_strb_q) : ac_q;
        md_d    = md_q;
        ir_d    = ir_q;
        skip_d  = skip_q;
        if (f_ts1) begin
            skip_d = 1'b0;
            pc_d   = add12(mar_q, 1'b1);
        end
        if (f_ts2) begin
            md_d = mem_rdata;
            ir_d = mem_rdata[fsc_pkg::MD_MSB -: 3];
        end
        if (f_ts3) begin
            if (augmented) begin
                ac_d = ac_result;
                if (skip_request) skip_d = 1'b1;
            end
            if (is_jmp) pc_d = eff_addr;
        end
        if (f_ts4) begin
            if (int_now) begin
                ir_d    = fsc_pkg::OPC_JMS;
                mar_d   = fsc_pkg::ADDR_ZERO;
                major_d = fsc_pkg::MJ_EXEC;
            end else if (augmented) begin
                mar_d   = seq_addr;
                major_d = fsc_pkg::MJ_FETCH;
            end else if (is_jmp) begin
                mar_d   = ind_bit ? eff_addr : pc_q;
                major_d = ind_bit ? fsc_pkg::MJ_DEFER
                                  : fsc_pkg::MJ_FETCH;
            end else begin
                mar_d   = eff_addr;
                major_d = ind_bit ? fsc_pkg::MJ_DEFER
                                  : fsc_pkg::MJ_EXEC;
            end
        end
        // defer and execute flows are outside this block: one idle
        // memory cycle, then back to fetch at the counter
        if (!in_fetch && ts_q == fsc_pkg::TS_FOUR) begin
            mar_d   = pc_q;
            major_d = fsc_pkg::MJ_FETCH;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ts_q     <= fsc_pkg::TS_IDLE;
            major_q  <= fsc_pkg::MJ_FETCH;
            pc_q     <= fsc_pkg::WORD_RESET;
            mar_q    <= fsc_pkg::WORD_RESET;
            ac_q     <= fsc_pkg::WORD_RESET;
            md_q     <= fsc_pkg::WORD_RESET;
            ir_q     <= fsc_pkg::OPC_AND;
            skip_q   <= 1'b0;
            run_q    <= 1'b0;
            int_s1_q <= 1'b0;
            int_s2_q <= 1'b0;
        end else begin
            ts_q     <= ts_d;
            major_q  <= major_d;
            pc_q     <= pc_d;
            mar_q    <= mar_d;
            ac_q     <= ac_d;
            md_q     <= md_d;
            ir_q     <= ir_d;
            skip_q   <= skip_d;
            int_s1_q <= interrupt_active;
            int_s2_q <= int_s1_q;
            if (wr_ctrl && w_strb_q[0])
                run_q <= w_data_q[fsc_pkg::CTRL_RUN_BIT];
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign time_state_one        = (ts_q == fsc_pkg::TS_ONE);
    assign time_state_two        = (ts_q == fsc_pkg::TS_TWO);
    assign time_state_three      = (ts_q == fsc_pkg::TS_THREE);
    assign time_state_four       = (ts_q == fsc_pkg::TS_FOUR);
    assign time_pulse_four       = time_state_four;
    assign major_state           = major_q;
    assign instruction_register  = ir_q;
    assign mem_addr              = mar_q;
    assign mem_read              = f_ts1 || f_ts2;
    assign mem_write             = f_ts3 || f_ts4;
    // low while the write-back word md_q owns the bus
    assign memory_data_direction = !(f_ts3 || f_ts4);
    assign memory_data_bus       = memory_data_direction
                                 ? mem_rdata : md_q;
    assign data_bus_en           = in_fetch && !idle;
    assign data_bus              = data_bus_en ? ac_q : 12'h000;
    assign carry_inject_n        = !(f_ts1 || (f_ts4 && skip_take));

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_skip_clear: assert property (f_ts1 |=> !skip_q)
        else $error("skip not cleared in first time state");
    chk_pc_incr: assert property (f_ts1 |=>
        pc_q == $past(mar_q) + 12'h001)
        else $error("counter not address plus one");
    chk_data_bus: assert property (f_ts2 |->
        data_bus_en && data_bus == ac_q)
        else $error("accumulator missing from data bus");
    chk_memory_data_direction: assert property (f_ts3 |-> !memory_data_direction ##1
        memory_data_bus == md_q)
        else $error("write-back data not on memory bus");
    chk_ir_decode: assert property (f_ts2 |=>
        ir_q == $past(mem_rdata[11:9]))
        else $error("opcode not decoded from top bits");
    chk_int_force: assert property (f_ts4 && int_now |=>
        mar_q == 12'h000 && ir_q == 3'h4 && major_q == fsc_pkg::MJ_EXEC)
        else $error("interrupt entry not forced");
    chk_skip_addr: assert property (f_ts4 && skip_take |=>
        mar_q == $past(pc_q) + 12'h001)
        else $error("skip did not advance address");
    chk_noskip_addr: assert property (f_ts4 && !int_now && augmented
        && !skip_q |=> mar_q == $past(pc_q))
        else $error("address not counter value");
    chk_page_zero: assert property (f_ts4 && !int_now && !augmented
        && !is_jmp && page_zero |=> mar_q[11:7] == 5'h00)
        else $error("page zero upper bits not cleared");
    chk_defer_set: assert property (defer_set |=>
        major_q == fsc_pkg::MJ_DEFER
        ##4 (major_q == fsc_pkg::MJ_FETCH || !run_q))
        else $error("defer not entered");
    chk_mri_no_ac: assert property (f_ts3 && !augmented |=>
        $stable(ac_q))
        else $error("reference op changed accumulator");

    cov_skip: cover property (f_ts4 && skip_take);
    cov_jms: cover property (f_ts4 && ins_kind == fsc_pkg::INS_JMS);
    cov_int: cover property (f_ts4 && int_now);
    cov_defer: cover property (defer_set ##1 !in_fetch);
endmodule // fsc_fetch_ctrl

// *** include/fsc_pkg.sv ***
// shared constants and types for the fetch state control block
package fsc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PC     = 8'h08;
    localparam logic [7:0] OFS_MAR    = 8'h0C;
    localparam logic [7:0] OFS_AC     = 8'h10;
    localparam logic [7:0] OFS_INSTR  = 8'h14;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RUN_BIT   = 0;
    localparam int ST_MAJOR_LSB   = 0;
    localparam int ST_TS_LSB      = 2;
    localparam int ST_SKIP_BIT    = 5;
    localparam int ST_INT_BIT     = 6;
    localparam int IN_OPC_LSB     = 12;
    localparam int IN_GRP_LSB     = 15;
    localparam int MD_MSB         = 11;
    localparam int MD_PAGE_BIT    = 7;
    localparam int MD_IND_BIT     = 8;
    localparam int MD_ELEVEN_BIT  = 0;
    localparam logic [11:0] WORD_RESET = 12'h000;
    localparam logic [11:0] ADDR_ZERO  = 12'h000;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ------------------------------------------------------------
    // opcodes and decode
    // ------------------------------------------------------------
    localparam logic [2:0] OPC_AND = 3'h0;
    localparam logic [2:0] OPC_TAD = 3'h1;
    localparam logic [2:0] OPC_ISZ = 3'h2;
    localparam logic [2:0] OPC_DCA = 3'h3;
    localparam logic [2:0] OPC_JMS = 3'h4;
    localparam logic [2:0] OPC_JMP = 3'h5;
    localparam logic [2:0] OPC_IOT = 3'h6;
    localparam logic [2:0] OPC_OPR = 3'h7;
    typedef enum logic [1:0] {
        MJ_FETCH, MJ_DEFER, MJ_EXEC
    } fsc_major_e;
    typedef enum logic [2:0] {
        TS_IDLE, TS_ONE, TS_TWO, TS_THREE, TS_FOUR
    } fsc_ts_e;
    typedef enum logic [1:0] {
        GRP_NONE, GRP_ONE, GRP_TWO, GRP_THREE
    } fsc_grp_e;
    typedef enum logic [2:0] {
        INS_AND, INS_TAD, INS_ISZ, INS_DCA, INS_JMS, INS_JMP, INS_IOT,
        INS_OPR
    } fsc_ins_e;
endpackage

// *** sim/fsc_mem_model.sv ***
// core memory model facing the fetch control block
`timescale 1ns/1ps
module fsc_mem_model (
    input  wire logic        aclk,
    input  wire logic [11:0] mem_addr,
    input  wire logic        mem_read,
    input  wire logic        mem_write,
    input  wire logic [11:0] memory_data_bus,
    input  wire logic        memory_data_direction,
    output logic      [11:0] mem_rdata
);
    logic [11:0] mem [0:4095];
    logic [11:0] last_q = 12'h000;
    // released lines show the inverse, so stale data never passes
    assign mem_rdata = mem_read ? mem[mem_addr] : ~last_q;
    always @(posedge aclk) begin
        if (mem_read)
            last_q <= mem[mem_addr];
        if (mem_write && !memory_data_direction)
            mem[mem_addr] <= memory_data_bus;
    end
endmodule // fsc_mem_model

// *** sim/tb_top.sv ***
// self-checking bench for the fetch state control block
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, skip_request = 1'b0;
    logic interrupt_active = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic [11:0] ac_result = 12'h000, mem_addr, mem_rdata, data_bus;
    logic [11:0] memory_data_bus, ac_e, m, w;
    logic [1:0] s_axi_bresp, s_axi_rresp, major_state, operate_group, r;
    logic [2:0] instruction_register;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mem_read, mem_write, memory_data_direction;
    logic data_bus_en, time_state_one, time_state_two, time_state_three;
    logic time_state_four, time_pulse_four, page_zero, carry_inject_n;
    logic fetch_set, defer_set, execute_set;
    int fails = 0, n_checks = 0;
    fsc_fetch_ctrl i_dut (.*);
    fsc_mem_model i_mem (.*);
    always #50 aclk = ~aclk;
    always @(posedge aclk) {skip_request, ac_result} <= 13'($urandom);
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axi(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        while (1'b1) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (wr ? s_axi_bvalid : s_axi_rvalid) begin
                {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
                {s_axi_bready, s_axi_rready} <= 2'h0;
                break;
            end
        end
    endtask
    // {next major state, next address} for word iw fetched from ia
    function automatic logic [13:0] nxt(logic [11:0] iw, ia, logic s, i);
        logic [11:0] t;
        t = {iw[7] ? ia[11:7] : 5'h00, iw[6:0]};
        if (i) return {2'h2, 12'h000};
        if (iw[11:10] == 2'h3) return {2'h0, ia + 12'h001 + 12'(s)};
        return {iw[8] ? 2'h1 : (iw[11:9] == 3'h5 ? 2'h0 : 2'h2), t};
    endfunction
    task automatic step();
        logic [13:0] x;
        logic sk, it;
        repeat (30) if (!time_state_one || major_state != 2'h0)
            @(posedge aclk) #1;
        m = mem_addr;
        w = i_mem.mem[m];
        chk("ts1", {time_state_one, carry_inject_n, mem_read, data_bus_en},
            4'hb);
        chk("acbus", data_bus, ac_e);
        // interrupt moves at ts1 so the synchroniser settles by ts4
        it = $urandom % 8 == 0;
        interrupt_active <= it;
        @(posedge aclk) #1;
        chk("ts2", {time_state_two, mem_read, memory_data_direction},
            3'h7);
        @(posedge aclk) #1;
        chk("wb", {time_state_three, memory_data_direction, mem_write},
            3'h5);
        chk("mdbus", memory_data_bus, w);
        chk("ir", instruction_register, w[11:9]);
        chk("grp", operate_group,
            w[11:9] != 3'h7 ? 2'h0 : {w[8], !w[8] | w[0]});
        sk = skip_request;
        if (w[11:10] == 2'h3) ac_e = ac_result;
        x = nxt(w, m, sk, it);
        @(posedge aclk) #1;
        chk("sets", {fetch_set, defer_set, execute_set}, 3'h4 >> x[13:12]);
        chk("ts4", {time_pulse_four, time_state_four, carry_inject_n,
            page_zero}, {2'h3, !(sk && !it && w[11:10] == 2'h3),
            !w[7]});
        @(posedge aclk) #1;
        chk("mar", {major_state, mem_addr}, x);
        if (it) chk("jms", instruction_register, 3'h4);
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #4_000_000;
        fails++;
        final_report();
    end
    initial begin
        void'($urandom(32'h0000_30a4));
        for (int k = 0; k < 4096; k++) i_mem.mem[k] = 12'($urandom);
        ac_e = 12'($urandom);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b1, fsc_pkg::OFS_STATUS, 32'h0000_0000);
        chk("ro_write", r, fsc_pkg::RESP_SLVERR);
        axi(1'b1, 8'h40, 32'h0000_0000);
        chk("unmapped", r, fsc_pkg::RESP_SLVERR);
        axi(1'b1, fsc_pkg::OFS_AC, 32'(ac_e));
        axi(1'b1, fsc_pkg::OFS_MAR, 32'h0000_0ab5);
        axi(1'b0, fsc_pkg::OFS_MAR, 32'h0000_0000);
        chk("mar_rw", q, 32'h0000_0ab5);
        chk("rd_resp", r, fsc_pkg::RESP_OKAY);
        axi(1'b0, fsc_pkg::OFS_AC, 32'h0000_0000);
        chk("ac_rw", q, 32'(ac_e));
        axi(1'b1, fsc_pkg::OFS_PC, 32'h0000_0123);
        chk("wr_resp", r, fsc_pkg::RESP_OKAY);
        axi(1'b0, fsc_pkg::OFS_PC, 32'h0000_0000);
        chk("pc_rw", q, 32'h0000_0123);
        axi(1'b0, 8'h40, 32'h0000_0000);
        chk("rd_unmapped", r, fsc_pkg::RESP_SLVERR);
        $display("test registers done");
        axi(1'b1, fsc_pkg::OFS_CTRL, 32'h0000_0001);
        #1;
        repeat (300) step();
        $display("test fetch done");
        final_report();
    end
endmodule // tb_top
